// ### ext_mem_model.sv
`timescale 1ns/1ps
module ext_mem_model
  import pbus_pkg::*;
(
  // Clock.
  input wire logic sys_clk,
  // Device pins and wait setting.
  input wire bus_out_t busOut,
  input wire bus_oe_t busOe,
  input wire logic [3:0] waitCycles,
  output logic readyN,
  output logic [DATA_W-1:0] dataIn
);
  logic [DATA_W-1:0] mem [16];
  logic [DATA_W-1:0] keepLevel;
  logic [3:0] cnt;
  logic active;
  assign active = busOe.strobe && !busOut.strobeN;
  // Undriven data lines keep their last level, as the pin keepers do.
  assign dataIn = busOe.data ? busOut.data :
      (active && busOut.readNotWrite) ? mem[busOut.addr[3:0]] : keepLevel;
  initial begin
    readyN = 1'b1;
    cnt = 4'h0;
    keepLevel = 32'hA5A55A5A;
    for (int i = 0; i < 16; i++) mem[i] = 32'h0;
  end
  always @(posedge sys_clk) begin
    keepLevel <= dataIn;
    if (!readyN) begin
      readyN <= 1'b1;
      cnt <= 4'h0;
      if (active && !busOut.readNotWrite) mem[busOut.addr[3:0]] <= busOut.data;
    end else if (active) begin
      // Ready is a one-cycle pulse, so a stale level never ends the next access.
      if (cnt == waitCycles) readyN <= 1'b0;
      else cnt <= cnt + 4'h1;
    end else cnt <= 4'h0;
  end
endmodule : ext_mem_model

// ### pbus_pkg.sv
package pbus_pkg;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 24;
  localparam int PAGE_N = 4;
  localparam int PAGE_SEL_HI = 23;
  localparam int PAGE_SEL_LO = 22;
  localparam logic [ADDR_W-1:0] PAGE0_TOP = 24'h3FFFFF;
  localparam logic [ADDR_W-1:0] PAGE1_BASE = 24'h400000;
  localparam logic [ADDR_W-1:0] RESET_VECTOR_ADDR = 24'h000000;
  localparam logic [PAGE_N-1:0] PAGE_IDLE = 4'hF;

  typedef struct packed {
    logic req;
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } core_req_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic [PAGE_N-1:0] pageN;
    logic strobeN;
    logic readNotWrite;
  } bus_out_t;

  typedef struct packed {
    logic addr;
    logic data;
    logic page;
    logic strobe;
    logic readNotWrite;
    logic holdGrant;
  } bus_oe_t;

  typedef enum logic [2:0] {
    ST_BOOT,
    ST_IDLE,
    ST_ACCESS,
    ST_HOLD_WAIT,
    ST_HOLD
  } bus_state_t;
endpackage : pbus_pkg

// ### primary_bus_port.sv
`timescale 1ns/1ps
// How it works
// - Direction high on reads, low on writes.
// - Access strobe asserted on every external access.
// - Four decoded page strobes, floated on hold/shutdown/reset.
// - Hold request waits for current transaction end.
// - Hold floats address, data, strobe, direction; pends.
// - Hold ends on request high or ignore bit.
// - Grant low only after bus floated.
// - Grant high on request high or ignore bit.
// - Data keepers hold last level when undriven.
// - Reset floats bus except the access strobe and the grant pin.
// - After reset, fetch starts at reset vector.
// - Shutdown floats every pin including grant.
// - Page ranges ascend in address quarters.
module primary_bus_port
  import pbus_pkg::*;
#(
  parameter logic [ADDR_W-1:0] RESET_VECTOR = RESET_VECTOR_ADDR
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rstn,
  // Core side.
  input wire core_req_t coreReq,
  input wire logic holdIgnoreBit,
  output logic coreAck,
  output logic [DATA_W-1:0] coreRdata,
  output logic bootFetch,
  // Pin inputs.
  input wire logic readyN,
  input wire logic holdReqN,
  input wire logic tristateShutdownN,
  input wire logic [DATA_W-1:0] dataIn,
  // Pin outputs and enables.
  output bus_out_t busOut,
  output bus_oe_t busOe,
  output logic holdGrantN
);
  logic rstSync;
  logic holdReqSync;
  logic shutdownSync;
  bus_state_t state_reg, state_next;
  bus_out_t out_reg, out_next;
  logic [DATA_W-1:0] keep_reg, keep_next;
  logic [DATA_W-1:0] rdata_reg, rdata_next;
  logic boot_reg, boot_next;
  logic ack;

  // Reset release path; sync instances also cover hold and shutdown.
  sync_2ff #(.WIDTH(1), .RESET_VAL(1'b0)) u_rst_sync (
    .clk(sys_clk),
    .rstN(rstn),
    .asyncIn(1'b1),
    .syncOut(rstSync)
  );

  sync_2ff #(.WIDTH(2), .RESET_VAL(2'h3)) u_in_sync (
    .clk(sys_clk),
    .rstN(rstn),
    .asyncIn({holdReqN, tristateShutdownN}),
    .syncOut({holdReqSync, shutdownSync})
  );

  function automatic logic [PAGE_N-1:0] pageDecode(input logic [ADDR_W-1:0] a);
    logic [PAGE_N-1:0] p;
    p = PAGE_IDLE;
    p[a[PAGE_SEL_HI:PAGE_SEL_LO]] = 1'b0;
    return p;
  endfunction : pageDecode

  logic holdWanted;
  assign holdWanted = !holdReqSync && !holdIgnoreBit;

  always_comb begin
    state_next = state_reg;
    out_next = out_reg;
    rdata_next = rdata_reg;
    boot_next = boot_reg;
    ack = 1'b0;
    unique case (state_reg)
      ST_BOOT: begin
        // First fetch comes from the reset vector.
        out_next.addr = RESET_VECTOR;
        out_next.readNotWrite = 1'b1;
        out_next.strobeN = 1'b0;
        out_next.pageN = pageDecode(RESET_VECTOR);
        boot_next = 1'b1;
        state_next = ST_ACCESS;
      end
      ST_IDLE: begin
        if (holdWanted) begin
          state_next = ST_HOLD;
        end else if (coreReq.req) begin
          out_next.addr = coreReq.addr;
          out_next.data = coreReq.wdata;
          out_next.readNotWrite = !coreReq.write;
          out_next.strobeN = 1'b0;
          out_next.pageN = pageDecode(coreReq.addr);
          state_next = ST_ACCESS;
        end
      end
      ST_ACCESS: begin
        // Address, strobe and direction stay frozen until ready.
        if (!readyN) begin
          if (out_next.readNotWrite) begin
            rdata_next = dataIn;
          end
          ack = !boot_reg;
          boot_next = 1'b0;
          out_next.strobeN = 1'b1;
          out_next.pageN = PAGE_IDLE;
          state_next = holdWanted ? ST_HOLD : ST_IDLE;
        end
      end
      ST_HOLD_WAIT: begin
        state_next = ST_HOLD;
      end
      ST_HOLD: begin
        if (!holdWanted) begin
          state_next = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstSync) begin
    if (!rstSync) begin
      state_reg <= ST_BOOT;
      out_reg <= '{addr: '0, data: '0, pageN: PAGE_IDLE, strobeN: 1'b1, readNotWrite: 1'b1};
      rdata_reg <= '0;
      boot_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      out_reg <= out_next;
      rdata_reg <= rdata_next;
      boot_reg <= boot_next;
    end
  end

  // The keeper mirrors the wire so a floating data bus reads its last level.
  logic dataDriven;
  assign dataDriven = busOe.data;
  always_comb begin
    keep_next = dataDriven ? out_reg.data : dataIn;
  end

  always_ff @(posedge sys_clk or negedge rstSync) begin
    if (!rstSync) begin
      keep_reg <= '0;
    end else begin
      keep_reg <= keep_next;
    end
  end

  logic inHold;
  logic shutdown;
  logic inReset;
  assign inHold = (state_reg == ST_HOLD);
  assign shutdown = !shutdownSync;
  assign inReset = !rstSync;

  always_comb begin
    busOut = out_reg;
    busOut.data = dataDriven ? out_reg.data : keep_reg;
  end

  // Grant is low only once the hold state is reached, where every output except the grant pin floats.
  assign holdGrantN = !inHold;

  always_comb begin
    busOe.addr = !(shutdown || inHold || inReset);
    busOe.readNotWrite = !(shutdown || inHold || inReset);
    busOe.page = !(shutdown || inHold || inReset);
    busOe.strobe = !(shutdown || inHold);
    busOe.data = !(shutdown || inHold || inReset) && (state_reg == ST_ACCESS)
                 && !out_reg.readNotWrite;
    busOe.holdGrant = !shutdown;
  end

  assign coreAck = ack;
  assign coreRdata = rdata_reg;
  assign bootFetch = boot_reg;

  // Shutdown corrupts state; recovery relies on the outside resetting with it released.

  chk_grant_floats: assert property (@(posedge sys_clk) disable iff (!rstSync)
    !holdGrantN |-> !busOe.addr && !busOe.strobe && !busOe.data && !busOe.readNotWrite)
    else $error("Grant low while bus driven");
  chk_grant_high: assert property (@(posedge sys_clk) disable iff (!rstSync)
    (holdReqSync || holdIgnoreBit) && state_reg != ST_HOLD |=> state_reg != ST_HOLD)
    else $error("Hold entered without request");
  chk_hold_release: assert property (@(posedge sys_clk) disable iff (!rstSync)
    inHold && !holdWanted |=> state_reg == ST_IDLE)
    else $error("Hold not released");
  chk_wait_stable: assert property (@(posedge sys_clk) disable iff (!rstSync)
    state_reg == ST_ACCESS && readyN |=> $stable(out_reg.addr) && !out_reg.strobeN)
    else $error("Bus changed during wait");
  chk_complete_first: assert property (@(posedge sys_clk) disable iff (!rstSync)
    state_reg == ST_ACCESS && readyN |=> state_reg == ST_ACCESS)
    else $error("Access abandoned before ready");
  chk_dir_write: assert property (@(posedge sys_clk) disable iff (!rstSync)
    state_reg == ST_IDLE && !holdWanted && coreReq.req |=>
      out_reg.readNotWrite == !$past(coreReq.write) && !out_reg.strobeN)
    else $error("Direction or strobe wrong");
  chk_page_onehot: assert property (@(posedge sys_clk) disable iff (!rstSync)
    state_reg == ST_ACCESS |-> out_reg.pageN == pageDecode(out_reg.addr))
    else $error("Page strobe decode wrong");
  chk_shutdown_float: assert property (@(posedge sys_clk) disable iff (!rstSync)
    shutdown |-> !busOe.holdGrant && !busOe.strobe && !busOe.page)
    else $error("Pin driven in shutdown");
  // No disable here: this one must watch the pins while the reset copy is low.
  chk_reset_float: assert property (@(posedge sys_clk)
    inReset |-> !busOe.addr && !busOe.data && !busOe.page && !busOe.readNotWrite)
    else $error("Bus driven during reset");
  chk_hold_pages: assert property (@(posedge sys_clk) disable iff (!rstSync)
    inHold |-> !busOe.page)
    else $error("Page strobes driven in hold");
  chk_boot_vector: assert property (@(posedge sys_clk) disable iff (!rstSync)
    boot_reg && state_reg == ST_ACCESS |-> out_reg.addr == RESET_VECTOR)
    else $error("Boot fetch not at reset vector");

  cov_read: cover property (@(posedge sys_clk) disable iff (!rstSync)
    state_reg == ST_ACCESS && out_reg.readNotWrite && !readyN && !boot_reg);
  cov_write_wait: cover property (@(posedge sys_clk) disable iff (!rstSync)
    state_reg == ST_ACCESS && !out_reg.readNotWrite && readyN);
  cov_hold: cover property (@(posedge sys_clk) disable iff (!rstSync)
    state_reg == ST_ACCESS ##1 inHold);
  cov_shutdown: cover property (@(posedge sys_clk) disable iff (!rstSync)
    shutdown);
endmodule : primary_bus_port

// ### sync_2ff.sv
`timescale 1ns/1ps
module sync_2ff #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rstN,
  // Data.
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  // The first stage is read only by the second stage to keep metastability contained.
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      meta_reg <= RESET_VAL;
      sync_reg <= RESET_VAL;
    end else begin
      meta_reg <= asyncIn;
      sync_reg <= meta_reg;
    end
  end

  assign syncOut = sync_reg;
endmodule : sync_2ff

// ### test_primary_bus_hold_tristate_port.sv
`timescale 1ns/1ps
`define CHECK(a, b) begin samplesChecked++; if ((a) !== (b)) begin errCount++; \
  $display("wrong value at %0t: got %h expected %h", $time, a, b); end end
module test_primary_bus_hold_tristate_port;
  import pbus_pkg::*;
  logic sys_clk = 1'b0, rstn = 1'b0, holdIgnoreBit = 1'b0, holdReqN = 1'b1;
  logic tristateShutdownN = 1'b1, coreAck, bootFetch, readyN, holdGrantN;
  logic [3:0] waitCycles = 4'h0;
  logic [DATA_W-1:0] coreRdata, dataIn, rd;
  core_req_t coreReq = '0;
  bus_out_t busOut;
  bus_oe_t busOe;
  int errCount = 0, samplesChecked = 0;
  always #4 sys_clk = ~sys_clk;
  primary_bus_port i_primary_bus_port (.sys_clk(sys_clk), .rstn(rstn), .coreReq(coreReq),
    .holdIgnoreBit(holdIgnoreBit), .coreAck(coreAck), .coreRdata(coreRdata),
    .bootFetch(bootFetch), .readyN(readyN), .holdReqN(holdReqN),
    .tristateShutdownN(tristateShutdownN), .dataIn(dataIn), .busOut(busOut),
    .busOe(busOe), .holdGrantN(holdGrantN));
  ext_mem_model i_ext_mem_model (.sys_clk(sys_clk), .busOut(busOut), .busOe(busOe),
    .waitCycles(waitCycles), .readyN(readyN), .dataIn(dataIn));
  always @(negedge sys_clk) begin
    if (rstn && tristateShutdownN && holdGrantN === 1'b0) `CHECK(busOe, bus_oe_t'(6'h01))
    if (bootFetch === 1'b1 && busOe.strobe && !busOut.strobeN) `CHECK(busOut.addr, RESET_VECTOR_ADDR)
  end
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", samplesChecked, errCount);
    if (errCount == 0 && samplesChecked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop
  task automatic wait_until(input int which);
    int n;
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (n < 300 && !(which == 0 ? bootFetch === 1'b0 :
        which == 1 ? coreAck === 1'b1 : holdGrantN === 1'b0));
    if (n >= 300) begin
      errCount++;
      report_and_stop();
    end
  endtask : wait_until
  task automatic access(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge sys_clk);
    coreReq <= '{1'b1, w, a, d};
    wait_until(1);
    `CHECK(busOe.strobe & ~busOut.strobeN, 1'b1)
    `CHECK(busOut.addr, a)
    `CHECK(busOut.readNotWrite, ~w)
    `CHECK(busOut.pageN, ~(4'h1 << a[PAGE_SEL_HI:PAGE_SEL_LO]))
    @(posedge sys_clk);
    coreReq.req <= 1'b0;
    @(negedge sys_clk);
    `CHECK(busOut.pageN, PAGE_IDLE)
    rd = coreRdata;
  endtask : access
  task automatic pages_scenario();
    logic [ADDR_W-1:0] addrs [5] = '{24'h000000, PAGE0_TOP, PAGE1_BASE, 24'h800000, 24'hC00000};
    for (int i = 0; i < 5; i++) begin
      waitCycles <= 4'(i);
      access(1'b1, addrs[i], 32'h1234_0000 + 32'(i));
      access(1'b0, addrs[i], 32'h0);
      `CHECK(rd, 32'h1234_0000 + 32'(i))
    end
  endtask : pages_scenario
  task automatic hold_scenario();
    waitCycles <= 4'h6;
    fork
      access(1'b1, 24'h000003, 32'h0BADF00D);
      begin
        repeat (3) @(posedge sys_clk);
        holdReqN <= 1'b0;
        @(negedge sys_clk);
        `CHECK(holdGrantN, 1'b1)
      end
    join
    wait_until(2);
    @(posedge sys_clk);
    coreReq <= '{1'b1, 1'b0, 24'h000003, 32'h0};
    repeat (6) @(negedge sys_clk) `CHECK(coreAck, 1'b0)
    @(posedge sys_clk);
    holdReqN <= 1'b1;
    wait_until(1);
    `CHECK(holdGrantN, 1'b1)
    `CHECK(dataIn, 32'h0BADF00D)
    @(posedge sys_clk);
    coreReq.req <= 1'b0;
    holdIgnoreBit <= 1'b1;
    holdReqN <= 1'b0;
    access(1'b1, 24'h400001, 32'h5);
    `CHECK(holdGrantN, 1'b1)
    @(posedge sys_clk);
    holdIgnoreBit <= 1'b0;
    wait_until(2);
    @(posedge sys_clk);
    holdReqN <= 1'b1;
  endtask : hold_scenario
  task automatic shutdown_scenario();
    @(posedge sys_clk);
    tristateShutdownN <= 1'b0;
    repeat (4) @(negedge sys_clk);
    `CHECK(busOe, bus_oe_t'(6'h00))
    @(posedge sys_clk);
    rstn <= 1'b0;
    tristateShutdownN <= 1'b1;
    repeat (4) @(negedge sys_clk);
    `CHECK(busOe, bus_oe_t'(6'h05))
    `CHECK(busOut.strobeN, 1'b1)
    @(posedge sys_clk);
    rstn <= 1'b1;
    // The boot fetch only starts once the reset copy has passed its flip-flops.
    repeat (4) @(posedge sys_clk);
    wait_until(0);
    access(1'b0, 24'h000003, 32'h0);
  endtask : shutdown_scenario
  initial begin
    repeat (12) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (4) @(posedge sys_clk);
    wait_until(0);
    pages_scenario();
    hold_scenario();
    shutdown_scenario();
    report_and_stop();
  end
endmodule : test_primary_bus_hold_tristate_port
